// File: aat_aux.sv
// Aux ADC readback, sensor routing, monitor modulator, tx test mode and id bytes.
// Assumes a same-clock memory port and radio state; the ADC sample is asynchronous.
// Function
// - Reading upper ADC result starts a readback and captures a fresh sample.
// - Sample is 8 bits: lower read gives [1:0], next upper read gives [7:2].
// - In receive state ADC is enabled and fed the signal strength level.
// - Source select register steers ADC input; 0x08 picks temperature sensor.
// - Temperature sensor powered only while aux power-down control holds 0x02.
// - One conversion takes about one microsecond.
// - Enabled monitor drives second-order sigma-delta of filter output on pin.
// - Tx test byte picks normal, random, preamble or carrier; 4-255 reserved.
// - Bytes 0x001-0x004 hold product and revision codes, high byte first.
// - Id bytes valid after power-up or wake; overwritten leaving standby on.
`timescale 1ns/1ps
`include "aat_defines.svh"

module aat_aux #(
  parameter logic [7:0] PROD_HI = 8'h5a,  // Arbitrary value
  parameter logic [7:0] PROD_LO = 8'h3c,  // Arbitrary value
  parameter logic [7:0] REV_HI  = 8'h01,  // Arbitrary value
  parameter logic [7:0] REV_LO  = 8'h02   // Arbitrary value
) (
  input  logic                      clk,
  input  logic                      sys_rst,
  input  logic [9:0]                mem_addr,
  input  logic                      mem_wr,
  input  logic                      mem_rd,
  input  logic [7:0]                mem_wdata,
  output logic [7:0]                mem_rdata,
  output logic                      mem_rvalid,
  input  aat_pkg::aat_radio_state_t radio_state,
  input  logic [7:0]                adc_sample_in,
  output logic                      adc_power_on,
  output logic                      adc_convert,
  output aat_pkg::aat_route_t       adc_route,
  output logic                      temp_sensor_power_on,
  input  logic [15:0]               filt_out,
  output logic                      monitor_output_pin,
  output logic                      monitor_output_oe_n,
  output aat_pkg::aat_tx_mode_t     tx_test_mode,
  output logic                      id_valid
);

  localparam int CONV_I = `AAT_CONV_CYC;
  // Phase leaves conversion one edge after the last count is seen
  localparam int CONV_DONE_I = CONV_I + 1;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register file and read port
  logic [7:0] txm_reg, txm_next, rx_pd_reg, rx_pd_next, aux_pd_reg, aux_pd_next;
  logic [7:0] src_reg, src_next, pin_reg, pin_next, gain_reg, gain_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;
  logic [7:0] sample_reg, sample_next;
  logic       id_valid_reg, id_valid_next;

  always_comb begin
    txm_next    = txm_reg;
    rx_pd_next  = rx_pd_reg;
    aux_pd_next = aux_pd_reg;
    src_next    = src_reg;
    pin_next    = pin_reg;
    gain_next   = gain_reg;
    if (mem_wr) begin
      unique case (mem_addr)
        `AAT_A_TX_MODE:  txm_next = mem_wdata;
        `AAT_A_RX_PD:    rx_pd_next = mem_wdata;
        `AAT_A_AUX_PD:   aux_pd_next = mem_wdata;
        `AAT_A_ADC_SRC:  src_next = mem_wdata;
        `AAT_A_PIN_FUNC: pin_next = mem_wdata;
        `AAT_A_MON_GAIN: gain_next = mem_wdata;
        default: ;
      endcase
    end
    rvalid_next = mem_rd;
    rdata_next  = 8'h00;
    if (mem_rd) begin
      unique case (mem_addr)
        `AAT_A_PROD_HI:  rdata_next = id_valid_reg ? PROD_HI : 8'h00;
        `AAT_A_PROD_LO:  rdata_next = id_valid_reg ? PROD_LO : 8'h00;
        `AAT_A_REV_HI:   rdata_next = id_valid_reg ? REV_HI : 8'h00;
        `AAT_A_REV_LO:   rdata_next = id_valid_reg ? REV_LO : 8'h00;
        `AAT_A_TX_MODE:  rdata_next = txm_reg;
        `AAT_A_RX_PD:    rdata_next = rx_pd_reg;
        `AAT_A_AUX_PD:   rdata_next = aux_pd_reg;
        `AAT_A_ADC_HI:   rdata_next = {2'h0, sample_reg[7:2]};
        `AAT_A_ADC_LO:   rdata_next = {6'h00, sample_reg[1:0]};
        `AAT_A_ADC_SRC:  rdata_next = src_reg;
        `AAT_A_PIN_FUNC: rdata_next = pin_reg;
        `AAT_A_MON_GAIN: rdata_next = gain_reg;
        default:         rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txm_reg    <= `AAT_RST_BYTE;
      rx_pd_reg  <= `AAT_RST_BYTE;
      aux_pd_reg <= `AAT_RST_BYTE;
      src_reg    <= `AAT_RST_BYTE;
      pin_reg    <= `AAT_RST_BYTE;
      gain_reg   <= `AAT_RST_BYTE;
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      txm_reg    <= txm_next;
      rx_pd_reg  <= rx_pd_next;
      aux_pd_reg <= aux_pd_next;
      src_reg    <= src_next;
      pin_reg    <= pin_next;
      gain_reg   <= gain_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign mem_rdata  = rdata_reg;
  assign mem_rvalid = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // ADC readback sequence
  // Sample bits are stable while sampled, so a plain two-stage sync is enough
  logic [7:0]          smp_s1_reg, smp_s2_reg;
  aat_pkg::aat_phase_t phase_reg, phase_next;
  logic [4:0]          cnt_reg, cnt_next;
  logic                rd_hi, rd_lo;
  logic                power_reg, power_next, temp_reg, temp_next;
  aat_pkg::aat_route_t route_reg, route_next;
  logic                in_rx;
  logic                conv_reg, conv_next;

  assign rd_hi = mem_rd && hit(mem_addr, `AAT_A_ADC_HI);
  assign rd_lo = mem_rd && hit(mem_addr, `AAT_A_ADC_LO);
  assign in_rx = (radio_state == aat_pkg::AAT_ST_RX);

  always_comb begin
    phase_next  = phase_reg;
    cnt_next    = cnt_reg;
    sample_next = sample_reg;
    unique case (phase_reg)
      aat_pkg::AAT_PH_IDLE: begin
        if (rd_hi) begin
          phase_next = aat_pkg::AAT_PH_CONV;
          cnt_next   = 5'h00;
        end
      end
      aat_pkg::AAT_PH_CONV: begin
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg == 5'(`AAT_CONV_CYC - 1)) begin
          sample_next = smp_s2_reg;
          phase_next  = aat_pkg::AAT_PH_LO;
        end
      end
      aat_pkg::AAT_PH_LO: begin
        if (rd_lo) begin
          phase_next = aat_pkg::AAT_PH_HI;
        end else if (rd_hi) begin
          phase_next = aat_pkg::AAT_PH_CONV;
          cnt_next   = 5'h00;
        end
      end
      aat_pkg::AAT_PH_HI: begin
        // Held sample closes the sequence only on the upper read
        if (rd_hi) begin
          phase_next = aat_pkg::AAT_PH_IDLE;
        end
      end
    endcase
    conv_next  = (phase_next == aat_pkg::AAT_PH_CONV);
    power_next = in_rx || (rx_pd_reg == `AAT_V_ADC_ON);
    temp_next  = (aux_pd_reg == `AAT_V_TEMP_ON);
    if (in_rx) begin
      route_next = aat_pkg::AAT_SRC_RSSI;
    end else if (src_reg == `AAT_V_SRC_TEMP) begin
      route_next = aat_pkg::AAT_SRC_TEMP;
    end else begin
      route_next = aat_pkg::AAT_SRC_EXT;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smp_s1_reg <= 8'h00;
      smp_s2_reg <= 8'h00;
      phase_reg  <= aat_pkg::AAT_PH_IDLE;
      cnt_reg    <= 5'h00;
      sample_reg <= 8'h00;
      conv_reg   <= 1'b0;
      power_reg  <= 1'b0;
      temp_reg   <= 1'b0;
      route_reg  <= aat_pkg::AAT_SRC_EXT;
    end else begin
      smp_s1_reg <= adc_sample_in;
      smp_s2_reg <= smp_s1_reg;
      phase_reg  <= phase_next;
      cnt_reg    <= cnt_next;
      sample_reg <= sample_next;
      conv_reg   <= conv_next;
      power_reg  <= power_next;
      temp_reg   <= temp_next;
      route_reg  <= route_next;
    end
  end

  assign adc_convert          = conv_reg;
  assign adc_power_on         = power_reg;
  assign temp_sensor_power_on = temp_reg;
  assign adc_route            = route_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor sigma-delta modulator
  // Wide integrators avoid wrap for half-scale input at unity gain
  logic signed [19:0] i1_reg, i1_next;
  logic signed [23:0] i2_reg, i2_next;
  logic               bit_reg, bit_next, oe_n_reg, oe_n_next;
  logic signed [15:0] x;
  logic               mon_en;

  assign mon_en = (pin_reg == `AAT_V_MON_ON);
  assign x      = $signed(filt_out) >>> gain_reg[3:0];

  always_comb begin
    i1_next   = 20'sh00000;
    i2_next   = 24'sh000000;
    bit_next  = 1'b0;
    oe_n_next = 1'b1;
    if (mon_en) begin
      i1_next   = i1_reg + 20'(x) - (bit_reg ? 20'sh08000 : -20'sh08000);
      i2_next   = i2_reg + 24'(i1_reg) - (bit_reg ? 24'sh008000 : -24'sh008000);
      bit_next  = ~i2_next[23];
      oe_n_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      i1_reg   <= 20'sh00000;
      i2_reg   <= 24'sh000000;
      bit_reg  <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      i1_reg   <= i1_next;
      i2_reg   <= i2_next;
      bit_reg  <= bit_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign monitor_output_pin  = bit_reg;
  assign monitor_output_oe_n = oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Radio state tracking: tx test mode and id validity
  aat_pkg::aat_radio_state_t prev_reg;
  aat_pkg::aat_tx_mode_t     txo_reg, txo_next;
  logic                      tx_entry, leave_on, leave_sleep;

  assign tx_entry    = (radio_state == aat_pkg::AAT_ST_TX) && (prev_reg != aat_pkg::AAT_ST_TX);
  assign leave_on    = (prev_reg == aat_pkg::AAT_ST_ON) && (radio_state != aat_pkg::AAT_ST_ON);
  assign leave_sleep = (prev_reg == aat_pkg::AAT_ST_SLEEP)
                       && (radio_state != aat_pkg::AAT_ST_SLEEP);

  always_comb begin
    txo_next = txo_reg;
    // Latched only at entry; later writes wait for the next entry
    if (radio_state != aat_pkg::AAT_ST_TX) begin
      txo_next = aat_pkg::AAT_TX_NORMAL;
    end else if (tx_entry) begin
      txo_next = (txm_reg > 8'h03) ? aat_pkg::AAT_TX_NORMAL
                                   : aat_pkg::aat_tx_mode_t'(txm_reg[1:0]);
    end
    id_valid_next = id_valid_reg;
    if (leave_sleep) begin
      id_valid_next = 1'b1;
    end else if (leave_on) begin
      id_valid_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_reg     <= aat_pkg::AAT_ST_OFF;
      txo_reg      <= aat_pkg::AAT_TX_NORMAL;
      id_valid_reg <= 1'b1;
    end else begin
      prev_reg     <= radio_state;
      txo_reg      <= txo_next;
      id_valid_reg <= id_valid_next;
    end
  end

  assign tx_test_mode = txo_reg;
  assign id_valid     = id_valid_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_start;
    (phase_reg == aat_pkg::AAT_PH_IDLE) && rd_hi;
  endsequence
  sequence s_conv_done;
    ##CONV_DONE_I (phase_reg == aat_pkg::AAT_PH_LO);
  endsequence

  property p_start;
    s_start |-> s_conv_done;
  endproperty
  a_start: assert property (p_start) else $error("readback did not convert");

  property p_conv_len;
    $rose(adc_convert) |-> ##[CONV_I:CONV_I] !adc_convert;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length");

  property p_lo;
    (phase_reg == aat_pkg::AAT_PH_LO) && rd_lo
      |=> mem_rvalid && (mem_rdata == {6'h00, $past(sample_reg[1:0])});
  endproperty
  a_lo: assert property (p_lo) else $error("lower result wrong");

  property p_hi;
    (phase_reg == aat_pkg::AAT_PH_HI) && rd_hi
      |=> (mem_rdata == {2'h0, sample_reg[7:2]}) && (phase_reg == aat_pkg::AAT_PH_IDLE);
  endproperty
  a_hi: assert property (p_hi) else $error("upper result wrong");

  property p_hold;
    (phase_reg != aat_pkg::AAT_PH_CONV) |=> $stable(sample_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("sample changed");

  property p_rx;
    in_rx |=> adc_power_on && (adc_route == aat_pkg::AAT_SRC_RSSI);
  endproperty
  a_rx: assert property (p_rx) else $error("rx routing");

  property p_temp;
    1'b1 |=> temp_sensor_power_on == $past(aux_pd_reg == `AAT_V_TEMP_ON);
  endproperty
  a_temp: assert property (p_temp) else $error("temp sensor power");

  property p_src;
    !in_rx && (src_reg == `AAT_V_SRC_TEMP) |=> adc_route == aat_pkg::AAT_SRC_TEMP;
  endproperty
  a_src: assert property (p_src) else $error("temp routing");

  property p_mon;
    !mon_en |=> monitor_output_oe_n && !monitor_output_pin;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor active when off");

  property p_tx;
    tx_entry && (txm_reg > 8'h03) |=> tx_test_mode == aat_pkg::AAT_TX_NORMAL;
  endproperty
  a_tx: assert property (p_tx) else $error("reserved tx mode used");

  property p_id;
    leave_on ##1 (mem_rd && hit(mem_addr, `AAT_A_PROD_HI)) |=> mem_rdata == 8'h00;
  endproperty
  a_id: assert property (p_id) else $error("id not overwritten");

endmodule

// File: aat_defines.svh
// Offsets, reset values, field codes and timing counts of the aux measurement block.
// Assumes an 8-bit memory access port with 10-bit addresses.
`ifndef AAT_DEFINES_SVH
`define AAT_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
`define AAT_A_PROD_HI   10'h001
`define AAT_A_PROD_LO   10'h002
`define AAT_A_REV_HI    10'h003
`define AAT_A_REV_LO    10'h004
`define AAT_A_TX_MODE   10'h00d
`define AAT_A_RX_PD     10'h324
`define AAT_A_AUX_PD    10'h325
`define AAT_A_ADC_HI    10'h327
`define AAT_A_ADC_LO    10'h328
`define AAT_A_ADC_SRC   10'h359
`define AAT_A_PIN_FUNC  10'h3fa
`define AAT_A_MON_GAIN  10'h3fd

////////////////////////////////////////////////////////////////////////////////
`define AAT_RST_BYTE    8'h00
`define AAT_V_ADC_ON    8'h10
`define AAT_V_TEMP_ON   8'h02
`define AAT_V_SRC_TEMP  8'h08
`define AAT_V_MON_ON    8'hc9

////////////////////////////////////////////////////////////////////////////////
`define AAT_CLK_NS      50
`define AAT_CONV_NS     1000
`define AAT_CONV_CYC    ((`AAT_CONV_NS + `AAT_CLK_NS - 1) / `AAT_CLK_NS)

`endif

// File: aat_pkg.sv
// Types shared by the aux measurement block.
// Assumes the radio controller encodes its state as below.
package aat_pkg;

  typedef enum logic [2:0] {
    AAT_ST_OFF   = 3'h0,
    AAT_ST_ON    = 3'h1,
    AAT_ST_RX    = 3'h2,
    AAT_ST_TX    = 3'h3,
    AAT_ST_SLEEP = 3'h4
  } aat_radio_state_t;

  typedef enum logic [1:0] {
    AAT_PH_IDLE = 2'h0,
    AAT_PH_CONV = 2'h1,
    AAT_PH_LO   = 2'h2,
    AAT_PH_HI   = 2'h3
  } aat_phase_t;

  typedef enum logic [1:0] {
    AAT_SRC_EXT  = 2'h0,
    AAT_SRC_RSSI = 2'h1,
    AAT_SRC_TEMP = 2'h2
  } aat_route_t;

  typedef enum logic [1:0] {
    AAT_TX_NORMAL   = 2'h0,
    AAT_TX_RANDOM   = 2'h1,
    AAT_TX_PREAMBLE = 2'h2,
    AAT_TX_CARRIER  = 2'h3
  } aat_tx_mode_t;

endpackage

// File: aat_host.sv
// Host processor model for the memory access port of the aux block.
// Assumes the bench calls its tasks; requests change only at the falling edge.
`timescale 1ns/1ps
`include "aat_defines.svh"

module aat_host (
  input  wire logic       clk,
  output logic [9:0]      mem_addr,
  output logic            mem_wr,
  output logic            mem_rd,
  output logic [7:0]      mem_wdata,
  input  wire logic [7:0] mem_rdata,
  input  wire logic       mem_rvalid
);
  initial begin
    mem_addr = 10'h000;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    mem_wdata = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request held for exactly the one taking edge
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge clk);
    mem_wr = 1'b0;
    // Stale data never left looking valid
    mem_wdata = ~d;
  endtask

  // Answer taken one cycle after the request; no pulse reads as unknown
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge clk);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge clk);
    mem_rd = 1'b0;
    d = (mem_rvalid === 1'b1) ? mem_rdata : 8'hxx;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic adc_on();
    wr(`AAT_A_RX_PD, `AAT_V_ADC_ON);
  endtask

  task automatic temp_on();
    wr(`AAT_A_AUX_PD, `AAT_V_TEMP_ON);
    wr(`AAT_A_ADC_SRC, `AAT_V_SRC_TEMP);
  endtask

  task automatic mon_on(input logic [7:0] gain);
    wr(`AAT_A_PIN_FUNC, `AAT_V_MON_ON);
    wr(`AAT_A_MON_GAIN, gain);
  endtask
endmodule

// File: aux_adc_and_test_features_bench.sv
// Self-checking bench of the aux measurement block, driven through aat_host.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
`include "aat_defines.svh"

module aux_adc_and_test_features_bench;
  localparam logic [31:0] IDS = 32'h9e4b_07c1;  // Arbitrary id codes
  logic                      clk;
  logic                      sys_rst;
  logic [9:0]                mem_addr;
  logic                      mem_wr;
  logic                      mem_rd;
  logic [7:0]                mem_wdata;
  logic [7:0]                mem_rdata;
  logic                      mem_rvalid;
  aat_pkg::aat_radio_state_t radio_state;
  logic [7:0]                adc_sample_in;
  logic                      adc_power_on;
  logic                      adc_convert;
  aat_pkg::aat_route_t       adc_route;
  logic                      temp_sensor_power_on;
  logic [15:0]               filt_out;
  logic                      monitor_output_pin;
  logic                      monitor_output_oe_n;
  aat_pkg::aat_tx_mode_t     tx_test_mode;
  logic                      id_valid;
  integer                    seed;
  integer                    n_errors;
  integer                    checks_done;
  integer                    cycles;
  integer                    ones;
  integer                    e;
  logic [7:0]                b;
  logic [7:0]                s;
  logic [3:0]                g;
  logic [9:0]                rw_a [6];

  aat_aux #(.PROD_HI(IDS[31:24]), .PROD_LO(IDS[23:16]), .REV_HI(IDS[15:8]),
    .REV_LO(IDS[7:0])) DUT (
    .clk(clk), .sys_rst(sys_rst), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .radio_state(radio_state), .adc_sample_in(adc_sample_in),
    .adc_power_on(adc_power_on), .adc_convert(adc_convert), .adc_route(adc_route),
    .temp_sensor_power_on(temp_sensor_power_on), .filt_out(filt_out),
    .monitor_output_pin(monitor_output_pin), .monitor_output_oe_n(monitor_output_oe_n),
    .tx_test_mode(tx_test_mode), .id_valid(id_valid));

  aat_host host (
    .clk(clk), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input integer n);
    repeat (n) @(negedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic aat_pkg::aat_tx_mode_t exp_mode(input logic [7:0] v);
    return (v > 8'h03) ? aat_pkg::AAT_TX_NORMAL : aat_pkg::aat_tx_mode_t'(v[1:0]);
  endfunction

  // Ones density of the modulator over 256 cycles
  function automatic integer exp_ones(input logic [15:0] f, input logic [3:0] sh);
    return (($signed(f) >>> sh) + 32768) / 256;
  endfunction

  // Bounded run: a hang counts as a mismatch
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 15044;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    sys_rst = 1'b1;
    radio_state = aat_pkg::AAT_ST_OFF;
    adc_sample_in = 8'h00;
    filt_out = 16'h0000;
    rw_a = '{`AAT_A_TX_MODE, `AAT_A_RX_PD, `AAT_A_AUX_PD, `AAT_A_ADC_SRC,
             `AAT_A_PIN_FUNC, `AAT_A_MON_GAIN};
    idle(10);
    sys_rst = 1'b0;
    for (int i = 1; i < 5; i++) begin
      host.wr(10'(i), 8'hff);
      host.rd(10'(i), b);
      chk(b, IDS[39 - 8 * i -: 8]);
    end
    foreach (rw_a[i]) begin
      host.rd(rw_a[i], b);
      chk(b, 8'h00);
      s = 8'($random(seed));
      host.wr(rw_a[i], s);
      host.rd(rw_a[i], b);
      chk(b, s);
      host.wr(rw_a[i], 8'h00);
    end
    host.wr(10'h200, 8'h5a);
    host.rd(10'h200, b);
    chk(b, 8'h00);
    host.adc_on();
    idle(3);
    chk(adc_power_on, 1'b1);
    for (int k = 0; k < 5; k++) begin
      s = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($random(seed));
      adc_sample_in = s;
      host.rd(`AAT_A_ADC_HI, b);
      chk(adc_convert, 1'b1);
      idle(20);
      chk(adc_convert, 1'b0);
      adc_sample_in = ~s;
      host.rd(`AAT_A_ADC_LO, b);
      chk(b, {6'h00, s[1:0]});
      host.rd(`AAT_A_ADC_HI, b);
      chk(b, {2'h0, s[7:2]});
    end
    host.wr(`AAT_A_RX_PD, 8'h00);
    host.temp_on();
    radio_state = aat_pkg::AAT_ST_RX;
    idle(3);
    chk(adc_route, aat_pkg::AAT_SRC_RSSI);
    chk(adc_power_on, 1'b1);
    radio_state = aat_pkg::AAT_ST_OFF;
    idle(3);
    chk(adc_route, aat_pkg::AAT_SRC_TEMP);
    chk(adc_power_on, 1'b0);
    chk(temp_sensor_power_on, 1'b1);
    host.wr(`AAT_A_AUX_PD, 8'h03);
    host.wr(`AAT_A_ADC_SRC, 8'h09);
    idle(3);
    chk(temp_sensor_power_on, 1'b0);
    chk(adc_route, aat_pkg::AAT_SRC_EXT);
    for (int k = 0; k < 7; k++) begin
      s = (k < 5) ? 8'(k) : (k == 5) ? 8'hff : 8'($random(seed));
      radio_state = aat_pkg::AAT_ST_ON;
      host.wr(`AAT_A_TX_MODE, s);
      radio_state = aat_pkg::AAT_ST_TX;
      idle(2);
      chk(tx_test_mode, exp_mode(s));
      host.wr(`AAT_A_TX_MODE, ~s);
      idle(2);
      chk(tx_test_mode, exp_mode(s));
      radio_state = aat_pkg::AAT_ST_ON;
      idle(2);
      chk(tx_test_mode, aat_pkg::AAT_TX_NORMAL);
    end
    for (int k = 0; k < 4; k++) begin
      filt_out = k[0] ? 16'hc000 : 16'h4000;
      if (k == 3) filt_out = 16'($random(seed) % 16384);
      g = k[1] ? 4'($random(seed) & 3) : 4'h0;
      host.mon_on({4'h0, g});
      idle(8);
      ones = 0;
      repeat (256) begin
        @(negedge clk);
        ones = ones + int'(monitor_output_pin);
      end
      e = exp_ones(filt_out, g);
      // Second-order loop: residue of a few counts only
      chk((ones > e - 5 && ones < e + 5) ? e : ones, e);
      chk(monitor_output_oe_n, 1'b0);
    end
    host.wr(`AAT_A_PIN_FUNC, 8'h00);
    idle(3);
    chk({monitor_output_pin, monitor_output_oe_n}, 2'b01);
    radio_state = aat_pkg::AAT_ST_SLEEP;
    idle(2);
    radio_state = aat_pkg::AAT_ST_OFF;
    idle(2);
    chk(id_valid, 1'b1);
    host.rd(`AAT_A_REV_LO, b);
    chk(b, IDS[7:0]);
    radio_state = aat_pkg::AAT_ST_ON;
    idle(2);
    radio_state = aat_pkg::AAT_ST_OFF;
    host.rd(`AAT_A_PROD_HI, b);
    chk(b, 8'h00);
    chk(id_valid, 1'b0);
    conclude();
  end
endmodule
